/* File: core/rac_defs.svh */
// Constants of the receive alarm status and interrupt mask block.
// -----------------------------------------------------------------
// Overview of operation
// - Line-unit status bit reads 1 while that unit 1..8 raises an interrupt.
// - Framer mask, bit n for framer n+1; 1 enables, 0 masks; resets zero.
// - Tester mask, bit n for tester n+1; 1 enables, 0 masks; resets zero.
// - Line-unit mask, bit n for unit n+1; 1 enables, 0 masks; resets zero.
// - Without integration, remote alarm declares after 16 consecutive 00FF patterns.
// - Without integration, remote alarm clears when at most 14 of 16 match.
// - ESF with integration: declare and clear only after persisting over 200 ms.
// - Format 0 takes bipolar on both inputs; 1 takes NRZ, ignores negative, no BPV.
// - Frame-loss bit 0 is high while the framer is out of sync.
// - Signal-loss bit 1 sets after 255 zeros on both inputs, or 2048 extended.
// - All-ones bit 2 sets while unframed all ones arrive.
// - Far-end alarm bit 3 sets while a remote alarm is received.
// - T1: status three bit 0 shows the programmed loop-up code.
// - E1: bit 0 shows distant multiframe alarm, two multiframes, also in CCS.
// - T1: status three bit 1 shows the programmed loop-down code.
// - E1: bit 1 shows a detected V5.2 link identification signal.
// - Status three bit 2 shows the programmed spare code.
// - Status three bit 3 sets after no receive clock edge for one channel time.
// - Latched status four bit 2 sets once per second, counted on receive clock.
// - T1: latched status seven bit 3 sets on a valid SLC-96 alignment.
// - A latched bit clears on host read and sets again on its next event.
// -----------------------------------------------------------------
`ifndef RAC_DEFS_SVH
`define RAC_DEFS_SVH

`define RAC_ADDR_RCR2   8'h14
`define RAC_ADDR_RX_CONTROL_THREE   8'h83
`define RAC_ADDR_LAT4   8'h93
`define RAC_ADDR_LAT7   8'h96
`define RAC_ADDR_RT1    8'hb0
`define RAC_ADDR_RT3    8'hb2
`define RAC_ADDR_LSTAT  8'hfb
`define RAC_ADDR_FMASK  8'hfc
`define RAC_ADDR_TMASK  8'hfd
`define RAC_ADDR_LMASK  8'hfe
`define RAC_ADDR_PAT0   8'he0
`define RAC_ADDR_EXT    8'he6
`define RAC_ADDR_BPV    8'he7
`define RAC_RST_BYTE    8'h00
`define RAC_RCR2_MASK   8'h1f
`define RAC_RX_CONTROL_THREE_MASK   8'ha3
`define RAC_B_REMOTE_ALARM_INTEGRATE_EN     1
`define RAC_B_SLCEN     4
`define RAC_B_IDF       7
`define RAC_B_EXT       0
`define RAC_B_ONESEC    2
`define RAC_B_SLC       3
`define RAC_FDL_ALARM   16'h00ff
`define RAC_RAI_HIST    16'hffff
`define RAC_RAI_CLR_MAX 5'd14
`define RAC_LOS_SHORT   12'd255
`define RAC_LOS_LONG    12'd2048
`define RAC_AIS_ONES    12'd2048
`define RAC_CODE_HITS   3'd4
`define RAC_CODE_GAP    6'd32
`define RAC_CLK_PS      5000
`define RAC_CHAN_NS     5181
`define RAC_RAI_INT_MS  200
`define RAC_RX_CLOCK_LOST_FLAG_CYC    ((`RAC_CHAN_NS * 1000 + `RAC_CLK_PS - 1) / `RAC_CLK_PS)
`define RAC_RAI_CYC     (`RAC_RAI_INT_MS * 64'd1000000000 / `RAC_CLK_PS)
`define RAC_T1_SEC      1544000
`define RAC_E1_SEC      2048000

`endif

/* File: core/rac_pkg.sv */
// Types shared by the receive alarm status block.
package rac_pkg;
    typedef logic [7:0]  rac_byte_t;
    typedef logic [15:0] rac_word_t;
    typedef enum logic [1:0] {
        RAC_CODE_UP,
        RAC_CODE_DOWN,
        RAC_CODE_SPARE
    } rac_code_t;
endpackage : rac_pkg

/* File: core/rac_rx_alarm.sv */
// Receive alarm detection, latched status and global interrupt masks.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "rac_defs.svh"
module rac_rx_alarm
    import rac_pkg::*;
#(
    parameter logic [25:0] RAI_INT_CYC = 26'(`RAC_RAI_CYC),
    parameter logic [21:0] T1_SEC_EDGES = 22'(`RAC_T1_SEC),
    parameter logic [21:0] E1_SEC_EDGES = 22'(`RAC_E1_SEC),
    parameter logic [11:0] SLC_PATTERN  = 12'h0e3
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_arst_n,
    input  wire logic [7:0]    i_addr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [7:0]    o_rdata,
    input  wire logic          i_rx_clk,
    input  wire logic          i_rx_positive_in,
    input  wire logic          i_rx_negative_in,
    input  wire logic          i_e1_mode,
    input  wire logic          i_esf_mode,
    input  wire logic          i_framer_in_sync,
    input  wire logic          i_fdl_stb,
    input  wire logic [15:0]   i_fdl_word,
    input  wire logic          i_mf_stb,
    input  wire logic          i_ts16_bit6,
    input  wire logic          i_v52_detect,
    input  wire logic          i_fs_stb,
    input  wire logic          i_fs_bit,
    input  wire logic [7:0]    i_framer_irq,
    input  wire logic [7:0]    i_tester_irq,
    input  wire logic [7:0]    i_line_unit_irq_flag,
    output logic               o_irq
);

    // -----------------------------------------------------------------
    // Helpers and registers
    // -----------------------------------------------------------------
    function automatic logic [4:0] f_ones16(input rac_word_t w);
        logic [4:0] n;
        n = 5'd0;
        for (int k = 0; k < 16; k++) begin
            n = n + 5'(w[k]);
        end
        return n;
    endfunction : f_ones16
    function automatic logic f_sat_inc(input logic [11:0] c, input logic [11:0] lim);
        return c < lim;
    endfunction : f_sat_inc
    rac_byte_t rcr2_r, rx_control_three_r, ext_r, fmask_r, tmask_r, lmask_r;
    rac_byte_t lat4_r, lat7_r, bpv_r;
    rac_byte_t pat_r [6];
    rac_byte_t rdata_nxt;
    logic      rd_lat4, rd_lat7, rd_bpv;
    assign rd_lat4 = i_rd && (i_addr == `RAC_ADDR_LAT4);
    assign rd_lat7 = i_rd && (i_addr == `RAC_ADDR_LAT7);
    assign rd_bpv  = i_rd && (i_addr == `RAC_ADDR_BPV);
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rcr2_r  <= `RAC_RST_BYTE;
            rx_control_three_r  <= `RAC_RST_BYTE;
            ext_r   <= `RAC_RST_BYTE;
            fmask_r <= `RAC_RST_BYTE;
            tmask_r <= `RAC_RST_BYTE;
            lmask_r <= `RAC_RST_BYTE;
            for (int k = 0; k < 6; k++) begin
                pat_r[k] <= `RAC_RST_BYTE;
            end
        end else if (i_wr) begin
            case (i_addr)
                `RAC_ADDR_RCR2:  rcr2_r  <= i_wdata & `RAC_RCR2_MASK;
                `RAC_ADDR_RX_CONTROL_THREE:  rx_control_three_r  <= i_wdata & `RAC_RX_CONTROL_THREE_MASK;
                `RAC_ADDR_EXT:   ext_r   <= {7'h00, i_wdata[`RAC_B_EXT]};
                `RAC_ADDR_FMASK: fmask_r <= i_wdata;
                `RAC_ADDR_TMASK: tmask_r <= i_wdata;
                `RAC_ADDR_LMASK: lmask_r <= i_wdata;
                default: begin
                    if (i_addr >= `RAC_ADDR_PAT0 && i_addr < `RAC_ADDR_EXT) begin
                        pat_r[3'(i_addr - `RAC_ADDR_PAT0)] <= i_wdata;
                    end
                end
            endcase
        end
    end

    logic nrz_mode, t1_mode;
    assign nrz_mode = rx_control_three_r[`RAC_B_IDF];
    assign t1_mode  = !i_e1_mode;

    // -----------------------------------------------------------------
    // Line sampling, violations and runs
    // -----------------------------------------------------------------
    // Async pins pass two flops; only the second is read, on the synced rising edge.
    logic [1:0] clk_s_r, pos_s_r, neg_s_r;
    logic       clk_d_r;
    logic       rx_edge, rx_rise;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clk_s_r <= 2'b00;
            pos_s_r <= 2'b00;
            neg_s_r <= 2'b00;
            clk_d_r <= 1'b0;
        end else begin
            clk_s_r <= {clk_s_r[0], i_rx_clk};
            pos_s_r <= {pos_s_r[0], i_rx_positive_in};
            neg_s_r <= {neg_s_r[0], i_rx_negative_in};
            clk_d_r <= clk_s_r[1];
        end
    end
    assign rx_edge = clk_s_r[1] ^ clk_d_r;
    assign rx_rise = clk_s_r[1] & !clk_d_r;
    logic pos_b, neg_b, mark;
    assign pos_b = pos_s_r[1];
    assign neg_b = nrz_mode ? 1'b0 : neg_s_r[1];
    assign mark  = pos_b | neg_b;
    logic       last_pol_r;
    logic [11:0] zeros_r, ones_r;
    logic        los_r;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            last_pol_r <= 1'b0;
            bpv_r      <= `RAC_RST_BYTE;
        end else begin
            if (rx_rise && !nrz_mode && (pos_b ^ neg_b)) begin
                last_pol_r <= pos_b;
            end
            // A violation on the read cycle is kept: the count restarts at one.
            if (rx_rise && !nrz_mode && (pos_b ^ neg_b) && (pos_b == last_pol_r)) begin
                bpv_r <= rd_bpv ? 8'h01 : bpv_r + 8'((bpv_r != 8'hff));
            end else if (rd_bpv) begin
                bpv_r <= `RAC_RST_BYTE;
            end
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            zeros_r <= 12'h000;
            ones_r  <= 12'h000;
            los_r   <= 1'b0;
        end else if (rx_rise) begin
            zeros_r <= mark ? 12'h000 : zeros_r + 12'(f_sat_inc(zeros_r, `RAC_LOS_LONG));
            ones_r  <= mark ? ones_r + 12'(f_sat_inc(ones_r, `RAC_AIS_ONES)) : 12'h000;
            if (mark) begin
                los_r <= 1'b0;
            end else if (zeros_r + 12'h001 >=
                         (ext_r[`RAC_B_EXT] ? `RAC_LOS_LONG : `RAC_LOS_SHORT)) begin
                los_r <= 1'b1;
            end
        end
    end
    logic ais;
    assign ais = !i_framer_in_sync && (ones_r >= `RAC_AIS_ONES);

    // -----------------------------------------------------------------
    // Remote alarm from the data link
    // -----------------------------------------------------------------
    rac_word_t   fdl_hist_r;
    logic        rai_raw_r, rai_r;
    logic [25:0] rai_tmr_r;
    logic        rai_integ;
    assign rai_integ = i_esf_mode && rcr2_r[`RAC_B_REMOTE_ALARM_INTEGRATE_EN];
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fdl_hist_r <= 16'h0000;
            rai_raw_r  <= 1'b0;
        end else if (i_fdl_stb) begin
            fdl_hist_r <= {fdl_hist_r[14:0], i_fdl_word == `RAC_FDL_ALARM};
            if ({fdl_hist_r[14:0], i_fdl_word == `RAC_FDL_ALARM} == `RAC_RAI_HIST) begin
                rai_raw_r <= 1'b1;
            end else if (f_ones16({fdl_hist_r[14:0], i_fdl_word == `RAC_FDL_ALARM})
                         <= `RAC_RAI_CLR_MAX) begin
                rai_raw_r <= 1'b0;
            end
        end
    end

    // Integration waits out the window, so a short far-end alarm gap does not drop it.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rai_r     <= 1'b0;
            rai_tmr_r <= 26'h0000000;
        end else if (!rai_integ || rai_raw_r == rai_r) begin
            rai_tmr_r <= 26'h0000000;
            if (!rai_integ) begin
                rai_r <= rai_raw_r;
            end
        end else if (rai_tmr_r >= RAI_INT_CYC) begin
            rai_r     <= rai_raw_r;
            rai_tmr_r <= 26'h0000000;
        end else begin
            rai_tmr_r <= rai_tmr_r + 26'h0000001;
        end
    end

    // -----------------------------------------------------------------
    // Loop-up, loop-down and spare codes
    // -----------------------------------------------------------------
    rac_word_t  bits_r;
    logic [2:0] hits_r [3];
    logic [5:0] gap_r  [3];
    logic [2:0] code_on;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bits_r <= 16'h0000;
        end else if (rx_rise) begin
            bits_r <= {bits_r[14:0], pos_b};
        end
    end
    // A code holds after a few matches with no long gap and drops after one.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int c = 0; c < 3; c++) begin
                hits_r[c] <= 3'd0;
                gap_r[c]  <= 6'd0;
            end
        end else if (rx_rise) begin
            for (int c = 0; c < 3; c++) begin
                if ({bits_r[14:0], pos_b} == {pat_r[2*c+1], pat_r[2*c]}) begin
                    gap_r[c]  <= 6'd0;
                    hits_r[c] <= hits_r[c] + 3'(hits_r[c] != `RAC_CODE_HITS);
                end else if (gap_r[c] == `RAC_CODE_GAP) begin
                    hits_r[c] <= 3'd0;
                end else begin
                    gap_r[c] <= gap_r[c] + 6'd1;
                end
            end
        end
    end
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            code_on[c] = hits_r[c] == `RAC_CODE_HITS;
        end
    end

    // -----------------------------------------------------------------
    // Distant multiframe alarm and receive clock loss
    // -----------------------------------------------------------------
    logic [1:0] mf_hist_r;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mf_hist_r <= 2'b00;
        end else if (i_mf_stb) begin
            mf_hist_r <= {mf_hist_r[0], i_ts16_bit6};
        end
    end
    logic [10:0] rx_clock_lost_flag_cnt_r;
    logic        rx_clock_lost_flag_r;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_clock_lost_flag_cnt_r <= 11'd0;
            rx_clock_lost_flag_r     <= 1'b0;
        end else if (rx_edge) begin
            rx_clock_lost_flag_cnt_r <= 11'd0;
            rx_clock_lost_flag_r     <= 1'b0;
        end else if (rx_clock_lost_flag_cnt_r >= 11'(`RAC_RX_CLOCK_LOST_FLAG_CYC - 1)) begin
            rx_clock_lost_flag_r <= 1'b1;
        end else begin
            rx_clock_lost_flag_cnt_r <= rx_clock_lost_flag_cnt_r + 11'd1;
        end
    end

    // -----------------------------------------------------------------
    // One-second timer and SLC-96 alignment
    // -----------------------------------------------------------------
    logic [21:0] sec_cnt_r;
    logic        sec_tick;
    logic [11:0] fs_r;
    logic        slc_evt;
    // Counted on receive clock edges: a lost clock stops it.
    assign sec_tick = rx_rise &&
                      (sec_cnt_r == (i_e1_mode ? E1_SEC_EDGES : T1_SEC_EDGES) - 22'd1);
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sec_cnt_r <= 22'd0;
        end else if (sec_tick) begin
            sec_cnt_r <= 22'd0;
        end else if (rx_rise) begin
            sec_cnt_r <= sec_cnt_r + 22'd1;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fs_r <= 12'h000;
        end else if (i_fs_stb) begin
            fs_r <= {fs_r[10:0], i_fs_bit};
        end
    end
    assign slc_evt = i_fs_stb && t1_mode && rcr2_r[`RAC_B_SLCEN] &&
                     ({fs_r[10:0], i_fs_bit} == SLC_PATTERN);
    // Latched status: a new event in the read cycle survives the clear.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lat4_r <= `RAC_RST_BYTE;
            lat7_r <= `RAC_RST_BYTE;
        end else begin
            if (sec_tick) begin
                lat4_r[`RAC_B_ONESEC] <= 1'b1;
            end else if (rd_lat4) begin
                lat4_r[`RAC_B_ONESEC] <= 1'b0;
            end
            if (slc_evt) begin
                lat7_r[`RAC_B_SLC] <= 1'b1;
            end else if (rd_lat7) begin
                lat7_r[`RAC_B_SLC] <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Real-time status, read port and interrupt
    // -----------------------------------------------------------------
    rac_byte_t rt1, rt3;
    assign rt1 = {4'h0, rai_r, ais, los_r, !i_framer_in_sync};
    assign rt3 = {4'h0, rx_clock_lost_flag_r, code_on[RAC_CODE_SPARE],
                  t1_mode ? code_on[RAC_CODE_DOWN] : i_v52_detect,
                  t1_mode ? code_on[RAC_CODE_UP] : &mf_hist_r};
    always_comb begin
        rdata_nxt = `RAC_RST_BYTE;
        case (i_addr)
            `RAC_ADDR_RCR2:  rdata_nxt = rcr2_r;
            `RAC_ADDR_RX_CONTROL_THREE:  rdata_nxt = rx_control_three_r;
            `RAC_ADDR_LAT4:  rdata_nxt = lat4_r;
            `RAC_ADDR_LAT7:  rdata_nxt = lat7_r;
            `RAC_ADDR_RT1:   rdata_nxt = rt1;
            `RAC_ADDR_RT3:   rdata_nxt = rt3;
            `RAC_ADDR_LSTAT: rdata_nxt = i_line_unit_irq_flag;
            `RAC_ADDR_FMASK: rdata_nxt = fmask_r;
            `RAC_ADDR_TMASK: rdata_nxt = tmask_r;
            `RAC_ADDR_LMASK: rdata_nxt = lmask_r;
            `RAC_ADDR_EXT:   rdata_nxt = ext_r;
            `RAC_ADDR_BPV:   rdata_nxt = bpv_r;
            default: begin
                if (i_addr >= `RAC_ADDR_PAT0 && i_addr < `RAC_ADDR_EXT) begin
                    rdata_nxt = pat_r[3'(i_addr - `RAC_ADDR_PAT0)];
                end
            end
        endcase
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= `RAC_RST_BYTE;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= `RAC_RST_BYTE;
        end
    end

    // This port's latched events raise framer 1 beside the external request.
    rac_byte_t framer_src;
    assign framer_src = i_framer_irq | {7'h00, |{lat4_r, lat7_r}};
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(framer_src & fmask_r) | |(i_tester_irq & tmask_r) |
                     |(i_line_unit_irq_flag & lmask_r);
        end
    end

endmodule : rac_rx_alarm

/* File: test/rac_rx_alarm_properties.sv */
// Checker of the mask registers, status reads and interrupt output.
`timescale 1ns/1ps
module rac_rx_alarm_chk (
    input  wire logic       i_ref_clk,
    input  wire logic       i_arst_n,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] o_rdata,
    input  wire logic       i_e1_mode,
    input  wire logic       i_framer_in_sync,
    input  wire logic       i_v52_detect,
    input  wire logic [7:0] i_framer_irq,
    input  wire logic [7:0] i_tester_irq,
    input  wire logic [7:0] i_line_unit_irq_flag,
    input  wire logic       o_irq
);
    logic [7:0] fm_r;
    logic [7:0] tm_r;
    logic [7:0] lm_r;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // ---------------------------------------------------------------
    // Shadow masks
    // ---------------------------------------------------------------
    // Masks mirrored from host writes.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fm_r <= 8'h00;
            tm_r <= 8'h00;
            lm_r <= 8'h00;
        end else if (i_wr) begin
            if (i_addr == 8'hfc) fm_r <= i_wdata;
            if (i_addr == 8'hfd) tm_r <= i_wdata;
            if (i_addr == 8'hfe) lm_r <= i_wdata;
        end
    end
    property p_fmask; i_rd && i_addr == 8'hfc |=> o_rdata == $past(fm_r); endproperty
    a_fmask: assert property (p_fmask) else $error("framer mask readback");
    property p_tmask; i_rd && i_addr == 8'hfd |=> o_rdata == $past(tm_r); endproperty
    a_tmask: assert property (p_tmask) else $error("tester mask readback");
    property p_lmask; i_rd && i_addr == 8'hfe |=> o_rdata == $past(lm_r); endproperty
    a_lmask: assert property (p_lmask) else $error("line mask readback");
    property p_lstat;
        i_rd && i_addr == 8'hfb |=> o_rdata == $past(i_line_unit_irq_flag);
    endproperty
    a_lstat: assert property (p_lstat) else $error("line status readback");
    property p_lof;
        i_rd && i_addr == 8'hb0 && $stable(i_framer_in_sync)
        && $past(i_framer_in_sync, 2) == i_framer_in_sync |=> o_rdata[0] == !$past(i_framer_in_sync);
    endproperty
    a_lof: assert property (p_lof) else $error("frame loss bit");
    property p_v52;
        i_rd && i_addr == 8'hb2 && i_e1_mode && i_v52_detect && $past(i_v52_detect, 2)
        && $past(i_e1_mode, 2) |=> o_rdata[1];
    endproperty
    a_v52: assert property (p_v52) else $error("link id bit");
    property p_irq_on;
        |((i_framer_irq & fm_r) | (i_tester_irq & tm_r) | (i_line_unit_irq_flag & lm_r)) |=> o_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt missing");
    property p_irq_off;
        fm_r == 8'h00 && (i_tester_irq & tm_r) == 8'h00
        && (i_line_unit_irq_flag & lm_r) == 8'h00 |=> !o_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt not masked");
endmodule : rac_rx_alarm_chk

bind rac_rx_alarm rac_rx_alarm_chk i_rac_rx_alarm_chk (.*);

/* File: test/rac_line_model.sv */
// Line-side model driving the receive clock and the line data pins.
`timescale 1ns/1ps
module rac_line_model (
    input  wire logic       i_run,
    input  wire logic [1:0] i_pattern,
    output logic            o_rx_clk,
    output logic            o_pos,
    output logic            o_neg
);
    logic pol_r = 1'b0;
    // ---------------------------------------------------------------
    // Line clock and data
    // ---------------------------------------------------------------
    // Pattern 0 sends zeros, 1 alternate marks, 2 marks on the negative pin only.
    // Data moves after the falling edge, far from the rising edge that samples it.
    initial begin
        o_rx_clk = 1'b0;
        o_pos = 1'b0;
        o_neg = 1'b0;
    end
    always begin
        #32;
        if (i_run) begin
            o_rx_clk = ~o_rx_clk;
            if (!o_rx_clk) begin
                pol_r = ~pol_r;
                o_pos = (i_pattern == 2'd1) && pol_r;
                o_neg = (i_pattern == 2'd2) || ((i_pattern == 2'd1) && !pol_r);
            end
        end
    end
endmodule : rac_line_model

/* File: test/tb_top.sv */
// Self-checking bench of the receive alarm status and interrupt mask block.
`timescale 1ns/1ps
module tb_top;
    import rac_pkg::*;
    logic       i_ref_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic       i_e1_mode = 1'b0, i_esf_mode = 1'b0, i_framer_in_sync = 1'b1;
    logic       i_fdl_stb = 1'b0, i_mf_stb = 1'b0, i_ts16_bit6 = 1'b0, o_irq;
    logic       i_v52_detect = 1'b0, i_fs_stb = 1'b0, i_fs_bit = 1'b0, run = 1'b0;
    logic       i_rx_clk, i_rx_positive_in, i_rx_negative_in;
    logic [1:0] pat = 2'd0;
    rac_byte_t  i_addr = 8'h00, i_wdata = 8'h00, o_rdata, d, fm, tm, lm;
    rac_byte_t  i_framer_irq = 8'h00, i_tester_irq = 8'h00, i_line_unit_irq_flag = 8'h00;
    rac_word_t  i_fdl_word = 16'h0000;
    int         errors = 0, cmp_count = 0, cycles = 0;
    integer     seed = 32'h9a42b16d;
    rac_byte_t  regs [5] = '{8'h14, 8'h83, 8'hfc, 8'hfd, 8'hfe};
    rac_byte_t  rmsk [5] = '{8'h1f, 8'ha3, 8'hff, 8'hff, 8'hff};

    rac_rx_alarm #(.RAI_INT_CYC(26'd20), .T1_SEC_EDGES(22'd8), .E1_SEC_EDGES(22'd8))
        i_rac_rx_alarm (.*);
    rac_line_model i_rac_line_model (.i_run(run), .i_pattern(pat), .o_rx_clk(i_rx_clk),
        .o_pos(i_rx_positive_in), .o_neg(i_rx_negative_in));

    always #2.5 i_ref_clk = ~i_ref_clk;

    task automatic complete_run();
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            errors++;
            complete_run();
        end
    end

    task automatic chk(input string n, input rac_byte_t e, input rac_byte_t g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input rac_byte_t a, input rac_byte_t v);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input rac_byte_t a, output rac_byte_t q);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(posedge i_ref_clk);
        q = o_rdata;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : cyc
    task automatic rc(input rac_byte_t a, m, e, input string n);
        cyc(2);
        rd(a, d);
        chk(n, e, d & m);
    endtask : rc
    task automatic strobe(input logic mf, input logic b, input rac_word_t w);
        @(posedge i_ref_clk);
        i_mf_stb <= mf;
        i_fdl_stb <= !mf;
        i_ts16_bit6 <= b;
        i_fdl_word <= w;
        @(posedge i_ref_clk);
        i_mf_stb <= 1'b0;
        i_fdl_stb <= 1'b0;
    endtask : strobe
    function automatic logic f_irq();
        return |((i_framer_irq & fm) | (i_tester_irq & tm) | (i_line_unit_irq_flag & lm));
    endfunction : f_irq

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        foreach (regs[j]) rc(regs[j], 8'hff, 8'h00, "reset value");
        for (int k = 0; k < 3; k++) begin
            foreach (regs[j]) begin
                wr(regs[j], 8'($random(seed)));
                rc(regs[j], 8'hff, i_wdata & rmsk[j], "readback");
            end
        end
        foreach (regs[j]) wr(regs[j], 8'h00);
        wr(8'h00, 8'hff);
        rc(8'h00, 8'hff, 8'h00, "unmapped");
        // Sparse sources and masks so that both interrupt levels occur.
        for (int k = 0; k < 10; k++) begin
            fm = 8'($random(seed) & $random(seed)) & 8'hfe;
            tm = 8'($random(seed) & $random(seed));
            lm = 8'($random(seed) & $random(seed));
            i_framer_irq <= 8'($random(seed) & $random(seed) & $random(seed));
            i_tester_irq <= 8'($random(seed) & $random(seed) & $random(seed));
            i_line_unit_irq_flag <= 8'($random(seed) & $random(seed) & $random(seed));
            wr(8'hfc, fm);
            wr(8'hfd, tm);
            wr(8'hfe, lm);
            rc(8'hfb, 8'hff, i_line_unit_irq_flag, "line status");
            chk("irq", {7'h0, f_irq()}, {7'h0, o_irq});
        end
        i_framer_in_sync <= 1'b0;
        rc(8'hb0, 8'h01, 8'h01, "frame loss");
        i_framer_in_sync <= 1'b1;
        rc(8'hb0, 8'h01, 8'h00, "frame loss");
        run <= 1'b1;
        cyc(3400);
        rc(8'hb0, 8'h02, 8'h02, "signal loss");
        pat <= 2'd2;
        cyc(3400);
        rc(8'hb0, 8'h02, 8'h00, "bipolar loss");
        wr(8'h83, 8'h80);
        cyc(3400);
        rc(8'hb0, 8'h02, 8'h02, "nrz loss");
        wr(8'h83, 8'h00);
        cyc(40);
        wr(8'he6, 8'h01);
        pat <= 2'd0;
        cyc(3400);
        rc(8'hb0, 8'h02, 8'h00, "long loss early");
        cyc(23300);
        rc(8'hb0, 8'h02, 8'h02, "long loss");
        pat <= 2'd1;
        i_framer_in_sync <= 1'b0;
        cyc(26700);
        rc(8'hb0, 8'h06, 8'h04, "all ones");
        i_framer_in_sync <= 1'b1;
        for (int k = 0; k < 15; k++) strobe(1'b0, 1'b0, 16'h00ff);
        rc(8'hb0, 8'h08, 8'h00, "far alarm 15");
        strobe(1'b0, 1'b0, 16'h00ff);
        rc(8'hb0, 8'h08, 8'h08, "far alarm 16");
        strobe(1'b0, 1'b0, 16'h00fe);
        rc(8'hb0, 8'h08, 8'h08, "far alarm 15 of 16");
        strobe(1'b0, 1'b0, 16'h01ff);
        rc(8'hb0, 8'h08, 8'h00, "far alarm 14 of 16");
        i_esf_mode <= 1'b1;
        wr(8'h14, 8'h02);
        for (int k = 0; k < 16; k++) strobe(1'b0, 1'b0, 16'h00ff);
        rc(8'hb0, 8'h08, 8'h00, "integrating");
        cyc(20);
        rc(8'hb0, 8'h08, 8'h08, "integrated");
        for (int k = 0; k < 4; k++) wr(8'(8'he0 + k), 8'h55);
        cyc(200);
        rc(8'hb2, 8'h07, 8'h03, "codes");
        i_e1_mode <= 1'b1;
        strobe(1'b1, 1'b1, 16'h0000);
        rc(8'hb2, 8'h01, 8'h00, "multiframe one");
        strobe(1'b1, 1'b1, 16'h0000);
        rc(8'hb2, 8'h01, 8'h01, "multiframe two");
        i_v52_detect <= 1'b1;
        rc(8'hb2, 8'h02, 8'h02, "link id");
        i_e1_mode <= 1'b0;
        i_v52_detect <= 1'b0;
        rc(8'h93, 8'h04, 8'h04, "one second");
        run <= 1'b0;
        cyc(1000);
        rc(8'hb2, 8'h08, 8'h00, "rx clock alive");
        cyc(100);
        rc(8'hb2, 8'h08, 8'h08, "rx clock lost");
        rd(8'h93, d);
        rc(8'h93, 8'h04, 8'h00, "second cleared");
        run <= 1'b1;
        cyc(200);
        rc(8'h93, 8'h04, 8'h04, "second again");
        rc(8'hb2, 8'h08, 8'h00, "rx clock back");
        complete_run();
    end
endmodule : tb_top
